// ==== cte_trap_unit.sv ====
// Overview of operation
// [RULE1] reset instruction: init 17us, pause 3.2us
// [RULE2] odd stack pointer references never trap
// [RULE3] missing device via stack traps restart
// [RULE4] copy word last cycle reads then writes
// [RULE5] clear and sign-extend last cycle read-write
// [RULE6] top register window is ordinary memory
// [RULE7] pc increment survives bus error
// [RULE8] autoincrement register still incremented on error
// [RULE9] halt stacks, psw 340, pc restart
// [RULE10] power-up start at restart address, nothing stacked
// [RULE11] bus error traps after instruction completes
// [RULE12] external event line interrupts at level 6
// [RULE13] acknowledge error: vector 0, restart, one instruction
// [RULE14] sixteen address bits only
// [RULE15] jumpered halt line: nmi via 140
// [RULE16] vector taken from data bits 7..2
// [RULE17] local vectors must not come from bus; the code only raises vec_conflict and still traps through the bus vector
// [RULE18] fixed arbitration order dma first, wait last
// [RULE19] sob rtt sxt xor kept, mark dropped
// [RULE20] trace trap precedes pending interrupt
// [RULE21] reserved opcode ranges trap through 10
`timescale 1ns/1ns
`default_nettype none
module cte_trap_unit
  import cte_pkg::*;
#(
  parameter int INIT_CYCLES = CTE_INIT_CYC
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // asynchronous pins
  input wire logic external_event_line,
  input wire logic halt_line,
  input wire logic halt_nmi_en,
  input wire logic pfail_line,
  input wire logic bus_irq,
  input wire logic dma_req,
  output logic dma_grant,
  // instruction sequencer
  input wire logic instr_valid,
  input wire logic [15:0] opcode,
  input wire logic instr_end,
  input wire logic wait_state,
  input wire logic [2:0] psw_pri,
  input wire logic psw_trace,
  output logic core_stall,
  // core memory access
  input wire logic acc_req,
  input wire logic acc_write,
  input wire logic acc_byte,
  input wire logic acc_via_sp,
  input wire logic acc_last,
  input wire logic [CTE_ADDR_W-1:0] acc_addr,
  output logic acc_ack,
  output logic acc_err,
  // bus engine
  output logic bus_req,
  output logic bus_write,
  output logic bus_iak,
  output logic [CTE_ADDR_W-1:0] bus_addr,
  input wire logic bus_done,
  input wire logic bus_timeout,
  input wire logic [15:0] data_address_lines,
  // system initialise and traps
  output logic init_out,
  output logic trap_req,
  output logic [7:0] trap_vec,
  output logic trap_restart,
  output logic trap_psw_load,
  output logic trap_no_stack,
  output logic vec_conflict
);
  typedef struct packed {
    cte_state_t st;
    logic boot_pend;
    logic bus_req;
    logic bus_write;
    logic bus_iak;
    logic [CTE_ADDR_W-1:0] bus_addr;
    logic rmw;
    logic rmw_class;
    logic acc_ack;
    logic acc_err;
    logic [CTE_CNT_W-1:0] cnt;
    logic init_out;
    logic busy;
    logic dma_gnt;
    logic buserr_pend;
    logic odd_pend;
    logic ill_pend;
    logic halt_pend;
    logic trace_armed;
    logic pf_pend;
    logic pf_old;
    logic ev_pend;
    logic ev_old;
    logic hl_pend;
    logic hl_old;
    logic inhibit;
    logic trap_req;
    logic [7:0] trap_vec;
    logic trap_restart;
    logic trap_psw_load;
    logic trap_no_stack;
    logic vec_conflict;
  } cte_regs_t;

  localparam logic [CTE_CNT_W-1:0] INIT_LAST = CTE_CNT_W'(INIT_CYCLES - 1);
  localparam logic [CTE_CNT_W-1:0] PAUSE_LAST = CTE_CNT_W'(CTE_PAUSE_CYC - 1);

  logic [0:0] rst_q;
  logic rst_n_s;
  logic [CTE_PIN_W-1:0] pins_s;
  logic ev_s;
  logic nmi_en_s;
  logic hl_s;
  logic pf_s;
  logic irq_s;
  logic dma_s;
  logic take;
  logic hi_pend;
  cte_regs_t r;
  cte_regs_t next_r;

  cte_sync2 #(.WIDTH(1)) u_rst_sync (
    .clk(ref_clk),
    .rst_n(resetn),
    .d(1'b1),
    .q(rst_q)
  );
  assign rst_n_s = rst_q[0];

  cte_sync2 #(.WIDTH(CTE_PIN_W)) u_pin_sync (
    .clk(ref_clk),
    .rst_n(rst_n_s),
    .d({dma_req, bus_irq, pfail_line, halt_line, halt_nmi_en, external_event_line}),
    .q(pins_s)
  );
  assign ev_s = pins_s[0];
  assign nmi_en_s = pins_s[1];
  assign hl_s = pins_s[2];
  assign pf_s = pins_s[3];
  assign irq_s = pins_s[4];
  assign dma_s = pins_s[5];

  // dma outranks every boundary action
  assign take = (instr_end || wait_state) && (r.st == CTE_S_IDLE) && !dma_s // RULE18
    && !r.boot_pend && !r.dma_gnt;
  assign hi_pend = r.buserr_pend || r.hl_pend || r.pf_pend || r.halt_pend
    || r.ill_pend || r.odd_pend;

  always_comb begin
    logic is_ill;
    logic is_rmw;
    logic [7:0] vec;
    is_ill = 1'b0;
    is_rmw = 1'b0;
    vec = 8'h00;
    next_r = r;
    next_r.acc_ack = 1'b0;
    next_r.acc_err = 1'b0;
    next_r.trap_req = 1'b0;
    next_r.trap_restart = 1'b0;
    next_r.trap_psw_load = 1'b0;
    next_r.trap_no_stack = 1'b0;
    next_r.vec_conflict = 1'b0;
    next_r.ev_old = ev_s;
    next_r.pf_old = pf_s;
    next_r.hl_old = hl_s;
    // mark and the shift, multiply, divide group are left out
    is_ill = (opcode >= CTE_ILL_A_LO && opcode <= CTE_ILL_A_HI) // RULE21
      || (opcode >= CTE_ILL_B_LO && opcode <= CTE_ILL_B_HI)
      || (opcode >= CTE_ILL_C_LO && opcode <= CTE_ILL_C_HI)
      || (opcode >= CTE_ILL_D_LO)
      || (opcode >= CTE_MARK_LO && opcode <= CTE_MARK_HI); // RULE19
    is_rmw = (opcode[15:12] == CTE_COPY_TOP) // RULE4
      || (opcode >= CTE_CLR_LO && opcode <= CTE_CLR_HI) // RULE5
      || (opcode >= CTE_CLRB_LO && opcode <= CTE_CLRB_HI)
      || (opcode >= CTE_SXT_LO && opcode <= CTE_SXT_HI);
    if (instr_end) begin
      next_r.trace_armed = 1'b0;
      next_r.inhibit = 1'b0;
    end
    if (instr_valid) begin
      next_r.rmw_class = is_rmw;
      // an untraced return defers the trace by one instruction
      next_r.trace_armed = psw_trace && (opcode != CTE_OP_RTT); // RULE20
    end
    case (r.st)
      CTE_S_IDLE: begin
        next_r.dma_gnt = dma_s && !r.bus_req; // RULE18
        if (r.boot_pend) begin
          next_r.boot_pend = 1'b0;
          next_r.trap_req = 1'b1; // RULE10
          next_r.trap_restart = 1'b1;
          next_r.trap_psw_load = 1'b1;
          next_r.trap_no_stack = 1'b1;
        end else if (take) begin
          if (r.buserr_pend) begin
            next_r.buserr_pend = 1'b0; // RULE11
            next_r.trap_req = 1'b1;
            next_r.trap_vec = CTE_VEC_ZERO;
            next_r.trap_restart = 1'b1; // RULE3
          end else if (r.hl_pend) begin
            next_r.hl_pend = 1'b0;
            next_r.trap_req = 1'b1; // RULE15
            next_r.trap_vec = CTE_VEC_HALTLINE;
          end else if (r.pf_pend) begin
            next_r.pf_pend = 1'b0;
            next_r.trap_req = 1'b1;
            next_r.trap_vec = CTE_VEC_PFAIL;
          end else if (r.halt_pend) begin
            next_r.halt_pend = 1'b0;
            next_r.trap_req = 1'b1; // RULE9
            next_r.trap_restart = 1'b1;
            next_r.trap_psw_load = 1'b1;
          end else if (r.ill_pend) begin
            next_r.ill_pend = 1'b0;
            next_r.trap_req = 1'b1; // RULE21
            next_r.trap_vec = CTE_VEC_ILL;
          end else if (r.odd_pend) begin
            next_r.odd_pend = 1'b0;
            next_r.trap_req = 1'b1;
            next_r.trap_vec = CTE_VEC_ODD;
          end else if (instr_end && r.trace_armed) begin
            next_r.trap_req = 1'b1; // RULE20
            next_r.trap_vec = CTE_VEC_TRACE;
          end else if (!r.inhibit && r.ev_pend && psw_pri < CTE_LVL_EVENT) begin
            next_r.ev_pend = 1'b0;
            next_r.trap_req = 1'b1; // RULE12
            next_r.trap_vec = CTE_VEC_EVENT;
          end else if (!r.inhibit && irq_s && psw_pri < CTE_LVL_BUS) begin
            next_r.st = CTE_S_IAK;
            next_r.bus_req = 1'b1;
            next_r.bus_iak = 1'b1;
            next_r.bus_write = 1'b0;
            next_r.bus_addr = '0;
          end
        end else if (instr_valid && opcode == CTE_OP_RESET) begin
          next_r.st = CTE_S_RST_INIT; // RULE1
          next_r.init_out = 1'b1;
          next_r.busy = 1'b1;
          next_r.cnt = '0;
        end else if (acc_req && !r.acc_ack && !dma_s && !r.dma_gnt) begin
          if (acc_addr[0] && !acc_byte && !acc_via_sp) begin // RULE2
            next_r.odd_pend = 1'b1;
            next_r.acc_ack = 1'b1;
            next_r.acc_err = 1'b1;
          end else begin
            // no address is held back for internal registers
            next_r.st = CTE_S_BUS; // RULE6
            next_r.bus_req = 1'b1;
            next_r.bus_iak = 1'b0;
            next_r.bus_addr = acc_addr; // RULE14
            next_r.rmw = acc_write && acc_last && r.rmw_class; // RULE4 RULE5
            next_r.bus_write = acc_write && !(acc_last && r.rmw_class);
          end
        end
      end
      CTE_S_BUS: begin
        if (bus_done || bus_timeout) begin
          next_r.bus_req = 1'b0;
          if (bus_timeout) begin
            next_r.buserr_pend = 1'b1; // RULE11
          end
          if (r.rmw && !r.bus_write) begin
            // a failed read still lets the instruction finish its write
            next_r.st = CTE_S_GAP; // RULE4 RULE5
          end else begin
            next_r.st = CTE_S_IDLE;
            // ack even on error so pc and register increments commit
            next_r.acc_ack = 1'b1; // RULE7 RULE8
            next_r.acc_err = bus_timeout || r.acc_err;
          end
        end
      end
      CTE_S_GAP: begin
        next_r.st = CTE_S_BUS;
        next_r.bus_req = 1'b1;
        next_r.bus_write = 1'b1; // RULE5
        next_r.rmw = 1'b0;
      end
      CTE_S_IAK: begin
        if (bus_done || bus_timeout) begin
          next_r.st = CTE_S_IDLE;
          next_r.bus_req = 1'b0;
          next_r.bus_iak = 1'b0;
          next_r.trap_req = 1'b1;
          if (bus_timeout) begin
            next_r.trap_vec = CTE_VEC_ZERO; // RULE13
            next_r.trap_restart = 1'b1;
            next_r.inhibit = 1'b1;
          end else begin
            vec = {data_address_lines[7:2], 2'b00}; // RULE16
            next_r.trap_vec = vec;
            next_r.vec_conflict = (vec == CTE_VEC_EVENT) // RULE17
              || (vec == CTE_VEC_HALTLINE) || (vec == CTE_VEC_PFAIL);
          end
        end
      end
      CTE_S_RST_INIT: begin
        next_r.cnt = CTE_CNT_W'(r.cnt + 1'b1);
        if (r.cnt == INIT_LAST) begin
          next_r.init_out = 1'b0; // RULE1
          next_r.cnt = '0;
          next_r.st = CTE_S_RST_PAUSE;
        end
      end
      CTE_S_RST_PAUSE: begin
        next_r.cnt = CTE_CNT_W'(r.cnt + 1'b1);
        if (r.cnt == PAUSE_LAST) begin
          // power fail stays pending until here
          next_r.busy = 1'b0; // RULE1
          next_r.st = CTE_S_IDLE;
        end
      end
      default: begin
        next_r.st = CTE_S_IDLE;
      end
    endcase
    if (r.st != CTE_S_IDLE) begin
      next_r.dma_gnt = 1'b0;
    end
    // sets come last so an event never loses to its own clear
    if (instr_valid && is_ill) begin
      next_r.ill_pend = 1'b1; // RULE21
    end
    if (instr_valid && opcode == CTE_OP_HALT) begin
      next_r.halt_pend = 1'b1; // RULE9
    end
    if (ev_s && !r.ev_old) begin
      next_r.ev_pend = 1'b1; // RULE12
    end
    if (pf_s && !r.pf_old) begin
      next_r.pf_pend = 1'b1;
    end
    if (hl_s && !r.hl_old && nmi_en_s) begin
      next_r.hl_pend = 1'b1; // RULE15
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      r <= '0;
      r.st <= CTE_S_IDLE;
      r.boot_pend <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  assign dma_grant = r.dma_gnt;
  assign core_stall = r.busy;
  assign acc_ack = r.acc_ack;
  assign acc_err = r.acc_err;
  assign bus_req = r.bus_req;
  assign bus_write = r.bus_write;
  assign bus_iak = r.bus_iak;
  assign bus_addr = r.bus_addr;
  assign init_out = r.init_out;
  assign trap_req = r.trap_req;
  assign trap_vec = r.trap_vec;
  assign trap_restart = r.trap_restart;
  assign trap_psw_load = r.trap_psw_load;
  assign trap_no_stack = r.trap_no_stack;
  assign vec_conflict = r.vec_conflict;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n_s);

  sequence s_rmw_read_end;
    r.st == CTE_S_BUS && r.rmw && !r.bus_write && (bus_done || bus_timeout);
  endsequence
  sequence s_rmw_write_start;
    !bus_req ##1 (bus_req && bus_write);
  endsequence

  property p_init_held;
    (r.st == CTE_S_RST_INIT && r.cnt < INIT_LAST) |=> init_out && core_stall;
  endproperty
  a_init_held: assert property (p_init_held) else $error("init dropped early"); // RULE1

  property p_pause_after_init;
    $fell(init_out) |-> core_stall && r.st == CTE_S_RST_PAUSE && r.cnt == '0;
  endproperty
  a_pause_after_init: assert property (p_pause_after_init) // RULE1
    else $error("no pause after init");

  property p_pf_blocked;
    core_stall |=> !(trap_req && trap_vec == CTE_VEC_PFAIL);
  endproperty
  a_pf_blocked: assert property (p_pf_blocked) else $error("pfail during reset"); // RULE1

  property p_sp_odd_goes_to_bus;
    (r.st == CTE_S_IDLE && !take && !r.boot_pend && !dma_s && !r.dma_gnt && acc_req
      && !r.acc_ack && acc_via_sp && acc_addr[0] && !(instr_valid && opcode == CTE_OP_RESET))
      |=> bus_req && bus_addr == $past(acc_addr) && !r.odd_pend;
  endproperty
  a_sp_odd_goes_to_bus: assert property (p_sp_odd_goes_to_bus) // RULE2
    else $error("odd stack access trapped");

  property p_rmw_order;
    s_rmw_read_end |=> s_rmw_write_start;
  endproperty
  a_rmw_order: assert property (p_rmw_order) else $error("rmw write missing"); // RULE4

  property p_buserr_restart;
    (take && r.buserr_pend) |=> trap_req && trap_restart && trap_vec == CTE_VEC_ZERO;
  endproperty
  a_buserr_restart: assert property (p_buserr_restart) // RULE3
    else $error("bus error not sent to restart");

  property p_err_still_acked;
    (r.st == CTE_S_BUS && bus_timeout && !(r.rmw && !r.bus_write)) |=> acc_ack && acc_err;
  endproperty
  a_err_still_acked: assert property (p_err_still_acked) // RULE7
    else $error("errored access not completed");

  property p_halt_psw;
    (trap_req && trap_psw_load) |-> trap_restart;
  endproperty
  a_halt_psw: assert property (p_halt_psw) else $error("psw load without restart"); // RULE9

  property p_iak_fail;
    (r.st == CTE_S_IAK && bus_timeout) |=> trap_req && trap_restart
      && trap_vec == CTE_VEC_ZERO && r.inhibit ##1 !bus_iak;
  endproperty
  a_iak_fail: assert property (p_iak_fail) else $error("bad iak error handling"); // RULE13

  property p_vec_bits;
    (r.st == CTE_S_IAK && bus_done) |=> trap_req
      && trap_vec == {$past(data_address_lines[7:2]), 2'b00};
  endproperty
  a_vec_bits: assert property (p_vec_bits) else $error("vector bits wrong"); // RULE16

  property p_trace_first;
    (take && instr_end && r.trace_armed && !hi_pend && r.ev_pend)
      |=> trap_req && trap_vec == CTE_VEC_TRACE;
  endproperty
  a_trace_first: assert property (p_trace_first) else $error("trace not first"); // RULE20

  property p_pf_over_event;
    (take && !r.buserr_pend && !r.hl_pend && r.pf_pend && r.ev_pend)
      |=> trap_req && trap_vec == CTE_VEC_PFAIL ##1 r.ev_pend;
  endproperty
  a_pf_over_event: assert property (p_pf_over_event) // RULE18
    else $error("priority order broken");
endmodule // cte_trap_unit
`default_nettype wire

// ==== cte_pkg.sv ====
`default_nettype none
package cte_pkg;
  // clock and sequencing times
  localparam int CTE_CLK_PERIOD_NS = 4;
  localparam int CTE_INIT_TIME_NS = 17000;
  localparam int CTE_PAUSE_TIME_NS = 3200;
  localparam int CTE_INIT_CYC = CTE_INIT_TIME_NS / CTE_CLK_PERIOD_NS;
  localparam int CTE_PAUSE_CYC =
    (CTE_PAUSE_TIME_NS + CTE_CLK_PERIOD_NS - 1) / CTE_CLK_PERIOD_NS;
  localparam int CTE_CNT_W = 13;
  localparam int CTE_ADDR_W = 16;
  // trap vectors and halt psw
  localparam logic [7:0] CTE_VEC_ZERO = 8'h00;
  localparam logic [7:0] CTE_VEC_ODD = 8'h04;
  localparam logic [7:0] CTE_VEC_ILL = 8'h08;
  localparam logic [7:0] CTE_VEC_TRACE = 8'h0c;
  localparam logic [7:0] CTE_VEC_PFAIL = 8'h14;
  localparam logic [7:0] CTE_VEC_EVENT = 8'h40;
  localparam logic [7:0] CTE_VEC_HALTLINE = 8'h60;
  localparam logic [7:0] CTE_HALT_PSW = 8'he0;
  // priority levels
  localparam logic [2:0] CTE_LVL_EVENT = 3'h6;
  localparam logic [2:0] CTE_LVL_BUS = 3'h4;
  // opcode decode
  localparam logic [15:0] CTE_OP_HALT = 16'h0000;
  localparam logic [15:0] CTE_OP_RESET = 16'h0005;
  localparam logic [15:0] CTE_OP_RTT = 16'h0006;
  localparam logic [15:0] CTE_ILL_A_LO = 16'h0088;
  localparam logic [15:0] CTE_ILL_A_HI = 16'h0097;
  localparam logic [15:0] CTE_ILL_B_LO = 16'h7000;
  localparam logic [15:0] CTE_ILL_B_HI = 16'h77ff;
  localparam logic [15:0] CTE_ILL_C_LO = 16'h7a00;
  localparam logic [15:0] CTE_ILL_C_HI = 16'h7bff;
  localparam logic [15:0] CTE_ILL_D_LO = 16'hf000;
  localparam logic [15:0] CTE_MARK_LO = 16'h0d00;
  localparam logic [15:0] CTE_MARK_HI = 16'h0d3f;
  localparam logic [3:0] CTE_COPY_TOP = 4'h1;
  localparam logic [15:0] CTE_CLR_LO = 16'h0a00;
  localparam logic [15:0] CTE_CLR_HI = 16'h0a3f;
  localparam logic [15:0] CTE_CLRB_LO = 16'h8a00;
  localparam logic [15:0] CTE_CLRB_HI = 16'h8a3f;
  localparam logic [15:0] CTE_SXT_LO = 16'h0dc0;
  localparam logic [15:0] CTE_SXT_HI = 16'h0dff;
  localparam int CTE_PIN_W = 6;
  typedef enum logic [2:0] {
    CTE_S_IDLE, CTE_S_BUS, CTE_S_GAP, CTE_S_IAK, CTE_S_RST_INIT, CTE_S_RST_PAUSE
  } cte_state_t;
endpackage
`default_nettype wire

// ==== cte_sync2.sv ====
`timescale 1ns/1ns
`default_nettype none
module cte_sync2
  import cte_pkg::*;
#(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // levels in and out
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } cte_sync_t;
  cte_sync_t r;
  cte_sync_t next_r;
  always_comb begin
    next_r.meta = d;
    next_r.stable = r.meta;
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end
  assign q = r.stable;
endmodule // cte_sync2
`default_nettype wire

// ==== cte_bus_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module cte_bus_model
  import cte_pkg::*;
#(
  parameter logic [15:0] NXM_LO = 16'h8000,
  parameter logic [15:0] NXM_HI = 16'h9fff
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // bus engine side
  input wire logic bus_req,
  input wire logic bus_iak,
  input wire logic [CTE_ADDR_W-1:0] bus_addr,
  output logic bus_done,
  output logic bus_timeout,
  output logic [15:0] data_address_lines,
  // bench controls
  input wire logic [3:0] delay,
  input wire logic [15:0] iak_vec,
  input wire logic iak_fail
);
  logic [1:0] st;
  logic [3:0] cnt;
  logic [15:0] last;
  logic miss;
  // nobody answers inside the hole, so the engine must time out
  assign miss = bus_iak ? iak_fail : (bus_addr >= NXM_LO && bus_addr <= NXM_HI);
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      st <= 2'h0;
      cnt <= 4'h0;
      last <= 16'h0000;
      bus_done <= 1'b0;
      bus_timeout <= 1'b0;
      data_address_lines <= 16'hffff;
    end else begin
      bus_done <= 1'b0;
      bus_timeout <= 1'b0;
      // released lines never repeat the last vector
      data_address_lines <= ~last;
      if (!bus_req) begin
        st <= 2'h0;
      end else if (st == 2'h0) begin
        st <= 2'h1;
        cnt <= delay;
      end else if (st == 2'h1 && cnt != 4'h0) begin
        cnt <= cnt - 4'h1;
      end else if (st == 2'h1) begin
        st <= 2'h2;
        bus_timeout <= miss;
        bus_done <= !miss;
        if (bus_iak && !miss) begin
          data_address_lines <= iak_vec;
          last <= iak_vec;
        end
      end
    end
  end
endmodule // cte_bus_model
`default_nettype wire

// ==== cte_trap_unit_bench.sv ====
`timescale 1ns/1ns
`default_nettype none
module cte_trap_unit_bench
  import cte_pkg::*;
;
  // shortened init phase keeps the run small
  localparam int INIT_T = 20;
  logic ref_clk, resetn, external_event_line, halt_line, halt_nmi_en, pfail_line, bus_irq;
  logic dma_req, instr_valid, instr_end, wait_state, psw_trace, acc_req, acc_write, acc_byte;
  logic acc_via_sp, acc_last, dma_grant, core_stall, acc_ack, acc_err, bus_req, bus_write;
  logic bus_iak, bus_done, bus_timeout, init_out, trap_req, trap_restart, trap_psw_load;
  logic trap_no_stack, vec_conflict, iak_fail, breq_q;
  logic [15:0] opcode, acc_addr, data_address_lines, bus_addr, iak_vec;
  logic [2:0] psw_pri;
  logic [7:0] trap_vec, bseq;
  logic [3:0] delay;
  logic [11:0] tv;
  int failures, tests_run, ntrap, nbus;

  cte_trap_unit #(.INIT_CYCLES(INIT_T)) cte_trap_unit_inst (.ref_clk, .resetn,
    .external_event_line, .halt_line, .halt_nmi_en, .pfail_line, .bus_irq, .dma_req,
    .dma_grant, .instr_valid, .opcode, .instr_end, .wait_state, .psw_pri, .psw_trace,
    .core_stall, .acc_req, .acc_write, .acc_byte, .acc_via_sp, .acc_last, .acc_addr,
    .acc_ack, .acc_err, .bus_req, .bus_write, .bus_iak, .bus_addr, .bus_done,
    .bus_timeout, .data_address_lines, .init_out, .trap_req, .trap_vec, .trap_restart,
    .trap_psw_load, .trap_no_stack, .vec_conflict);
  cte_bus_model cte_bus_model_inst (.ref_clk, .resetn, .bus_req, .bus_iak, .bus_addr,
    .bus_done, .bus_timeout, .data_address_lines, .delay, .iak_vec, .iak_fail);

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    if (trap_req === 1'b1) begin
      ntrap++;
      tv = {vec_conflict, trap_restart, trap_psw_load, trap_no_stack, trap_vec};
    end
    if (bus_req === 1'b1 && breq_q !== 1'b1) begin
      nbus++;
      bseq = {bseq[6:0], bus_write};
    end
    breq_q = bus_req;
  end

  task automatic finish_test();
    $display("compares %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [11:0] g, input logic [11:0] e);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic ins(input logic [15:0] op);
    @(posedge ref_clk);
    instr_valid <= 1'b1;
    opcode <= op;
    @(posedge ref_clk);
    instr_valid <= 1'b0;
    #1;
  endtask

  // pins pass two sync flops, so let them settle before the boundary
  task automatic bt(input int n, input logic [11:0] e, input logic [11:0] m);
    int t0;
    t0 = ntrap;
    repeat (5) @(posedge ref_clk);
    instr_end <= 1'b1;
    @(posedge ref_clk);
    instr_end <= 1'b0;
    repeat (12) @(posedge ref_clk);
    #1;
    chk(12'(ntrap - t0), 12'(n));
    if (n != 0) chk(tv & m, e);
  endtask

  task automatic acc(input logic w, sp, input logic [15:0] a, input int nb, input logic e);
    int i;
    int b0;
    logic got;
    b0 = nbus;
    got = 1'bx;
    @(posedge ref_clk);
    acc_req <= 1'b1;
    acc_write <= w;
    acc_last <= w;
    acc_via_sp <= sp;
    acc_addr <= a;
    for (i = 0; i < 100; i++) begin
      @(posedge ref_clk);
      if (acc_ack === 1'b1) begin
        got = acc_err;
        acc_req <= 1'b0;
        break;
      end
    end
    repeat (2) @(posedge ref_clk);
    #1;
    chk(12'(got), 12'(e));
    chk(12'(nbus - b0), 12'(nb));
  endtask

  task automatic t_reset_instr();
    int i;
    int ni;
    int ns;
    int t0;
    ni = 0;
    ns = 0;
    ins(CTE_OP_RESET);
    for (i = 0; i < 8 && core_stall !== 1'b1; i++) begin
      @(posedge ref_clk);
      #1;
    end
    t0 = ntrap;
    while (core_stall === 1'b1 && ns < 2000) begin
      ni += int'(init_out === 1'b1);
      ns++;
      @(posedge ref_clk);
      if (ns == 100) pfail_line <= 1'b1;
      #1;
    end
    chk(12'(ni), 12'(INIT_T));
    chk(12'(ns), 12'(INIT_T + CTE_PAUSE_CYC));
    chk(12'(ntrap - t0), 12'h000);
    bt(1, {4'h0, CTE_VEC_PFAIL}, 12'hfff);
    @(posedge ref_clk);
    pfail_line <= 1'b0;
    $display("reset instruction done");
  endtask

  task automatic t_ops();
    logic [15:0] bad [9] = '{16'h0088, 16'h0097, 16'h7000, 16'h77ff, 16'h7a00,
      16'h7bff, 16'hf000, 16'hffff, 16'h0d00};
    logic [15:0] good [6] = '{16'h0087, 16'h0098, 16'h7800, 16'h7e00, 16'h0dc0, 16'h0006};
    ins(CTE_OP_HALT);
    bt(1, 12'h600, 12'hf00);
    foreach (bad[i]) begin
      ins(bad[i]);
      bt(1, 12'h008, 12'hfff);
    end
    foreach (good[i]) begin
      ins(good[i]);
      bt(0, 12'h000, 12'h000);
    end
    $display("opcode traps done");
  endtask

  task automatic t_acc();
    int t0;
    logic [15:0] op [5] = '{16'h1000, 16'h0a00, 16'h8a00, 16'h0dc0, 16'h6000};
    acc(1'b0, 1'b1, 16'h1001, 1, 1'b0);
    bt(0, 12'h000, 12'h000);
    acc(1'b0, 1'b0, 16'h1001, 0, 1'b1);
    bt(1, {4'h0, CTE_VEC_ODD}, 12'hfff);
    t0 = ntrap;
    acc(1'b0, 1'b1, 16'h8000, 1, 1'b1);
    chk(12'(ntrap - t0), 12'h000);
    bt(1, 12'h400, 12'hdff);
    acc(1'b0, 1'b0, 16'hffc0, 1, 1'b0);
    acc(1'b0, 1'b0, 16'hffce, 1, 1'b0);
    @(posedge ref_clk);
    delay <= 4'h3;
    foreach (op[i]) begin
      ins(op[i]);
      acc(1'b1, 1'b0, 16'h0200, (i < 4) ? 2 : 1, 1'b0);
      chk(12'(bseq[1:0]), (i < 4) ? 12'h001 : 12'h003);
    end
    @(posedge ref_clk);
    delay <= 4'h0;
    $display("memory access done");
  endtask

  task automatic t_irq();
    @(posedge ref_clk);
    psw_pri <= 3'h6;
    external_event_line <= 1'b1;
    bt(0, 12'h000, 12'h000);
    @(posedge ref_clk);
    psw_pri <= 3'h5;
    bt(1, {4'h0, CTE_VEC_EVENT}, 12'hfff);
    @(posedge ref_clk);
    external_event_line <= 1'b0;
    psw_pri <= 3'h7;
    halt_line <= 1'b1;
    bt(0, 12'h000, 12'h000);
    @(posedge ref_clk);
    halt_line <= 1'b0;
    halt_nmi_en <= 1'b1;
    @(posedge ref_clk);
    halt_line <= 1'b1;
    bt(1, 12'h060, 12'hfff);
    @(posedge ref_clk);
    halt_line <= 1'b0;
    psw_pri <= 3'h3;
    bus_irq <= 1'b1;
    iak_vec <= 16'h013f;
    bt(1, 12'h03c, 12'hfff);
    @(posedge ref_clk);
    iak_vec <= {8'h00, CTE_VEC_EVENT};
    bt(1, {4'h8, CTE_VEC_EVENT}, 12'h8ff);
    @(posedge ref_clk);
    iak_fail <= 1'b1;
    bt(1, 12'h400, 12'hdff);
    @(posedge ref_clk);
    iak_fail <= 1'b0;
    bt(0, 12'h000, 12'h000);
    @(posedge ref_clk);
    bus_irq <= 1'b0;
    $display("interrupts done");
  endtask

  task automatic t_prio();
    ins(16'h7000);
    @(posedge ref_clk);
    // event pends under pfail so the arbitration order is exercised
    pfail_line <= 1'b1;
    external_event_line <= 1'b1;
    bt(1, {4'h0, CTE_VEC_PFAIL}, 12'hfff);
    bt(1, 12'h008, 12'hfff);
    @(posedge ref_clk);
    pfail_line <= 1'b0;
    psw_trace <= 1'b1;
    psw_pri <= 3'h0;
    // trace is armed only by an instruction decoded with the bit set
    ins(16'h1000);
    bt(1, {4'h0, CTE_VEC_TRACE}, 12'hfff);
    @(posedge ref_clk);
    psw_trace <= 1'b0;
    bt(1, {4'h0, CTE_VEC_EVENT}, 12'hfff);
    @(posedge ref_clk);
    external_event_line <= 1'b0;
    dma_req <= 1'b1;
    repeat (5) @(posedge ref_clk);
    #1;
    chk(12'(dma_grant), 12'h001);
    @(posedge ref_clk);
    dma_req <= 1'b0;
    wait_state <= 1'b1;
    external_event_line <= 1'b1;
    bt(1, {4'h0, CTE_VEC_EVENT}, 12'hfff);
    @(posedge ref_clk);
    wait_state <= 1'b0;
    external_event_line <= 1'b0;
    $display("priority done");
  endtask

  initial begin
    {resetn, external_event_line, halt_line, halt_nmi_en, pfail_line, bus_irq} = '0;
    {dma_req, instr_valid, instr_end, wait_state, psw_trace, acc_req, acc_write} = '0;
    {acc_byte, acc_via_sp, acc_last, iak_fail, breq_q} = '0;
    {opcode, acc_addr, iak_vec, psw_pri, delay, tv, bseq} = '0;
    repeat (16) @(posedge ref_clk);
    resetn <= 1'b1;
    repeat (8) @(posedge ref_clk);
    #1;
    chk(12'(ntrap), 12'h001);
    chk(12'(tv[10:8]), 12'h007);
    $display("power-up start done");
    t_reset_instr();
    t_ops();
    t_acc();
    t_irq();
    t_prio();
    finish_test();
  end

  initial begin
    repeat (20000) @(posedge ref_clk);
    failures++;
    finish_test();
  end
endmodule // cte_trap_unit_bench
`default_nettype wire
